// >>> rtl/ccs_clock_source.v
// clock source selection and synthesizer control, with APB register access
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"

module ccs_clock_source #(
    parameter LOCK_REF_EDGES = `CCS_LOCK_REF_EDGES,
    parameter REF_TIMEOUT = `CCS_REF_TIMEOUT_CYCLES,
    parameter RING_HALF = `CCS_RING_HALF_CYCLES
) (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // clock pins
    input wire REF_CLOCK_IN,
    output wire CORE_CLOCK_OUT,
    // wake pins that clear the halt bit
    input wire EXT_WAKE0,
    input wire EXT_WAKE1,
    // synthesizer and oscillator state
    output wire SYNTH_POWER_ON,
    output wire RING_OSC_POWER_ON,
    output wire LOOP_SETTLED
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // input divide count from its code
    function [3:0] n_from_code;
        input [2:0] code;
        begin
            if (code == `CCS_NCODE_ONE)
                n_from_code = 4'h1;
            else
                n_from_code = {1'b0, code} + 4'h2;
        end
    endfunction

    // feedback divide count from its code
    function [5:0] m_from_code;
        input [4:0] code;
        begin
            m_from_code = {1'b0, code} + 6'h02;
        end
    endfunction

    // address decode shared by read and write
    function [1:0] decode;
        input [7:0] addr;
        begin
            case (addr)
                `CCS_OFS_SYNTH_CONTROL: decode = 2'h1;
                `CCS_OFS_STATUS: decode = 2'h2;
                `CCS_OFS_POWER_CONTROL: decode = 2'h3;
                default: decode = 2'h0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    reg [15:0] synth_control_reg;
    reg [1:0] power_control_reg;
    reg lock_reg;
    reg detect_on_reg;
    reg [4:0] lock_cnt_reg;
    reg ref_d_reg;
    reg [9:0] ref_period_cnt_reg;
    reg [9:0] ref_period_reg;
    reg ref_present_reg;
    reg [14:0] vco_acc_reg;
    reg synth_lvl_reg;
    reg [7:0] ring_cnt_reg;
    reg ring_lvl_reg;

    wire [1:0] sel_slot = decode(PADDR);
    wire wr_en = PSEL && PENABLE && PWRITE && (sel_slot != 2'h0);
    wire synth_wr = wr_en && (sel_slot == 2'h1);
    wire power_wr = wr_en && (sel_slot == 2'h3);
    wire synth_power = synth_control_reg[`CCS_SC_POWER_BIT];
    wire synth_sel = synth_control_reg[`CCS_SC_SELECT_BIT];
    wire ring_sel = power_control_reg[`CCS_PC_RING_BIT];
    wire halt_req = power_control_reg[`CCS_PC_HALT_BIT];
    wire [3:0] n_val = n_from_code(synth_control_reg[`CCS_SC_NCODE_HI:`CCS_SC_NCODE_LO]);
    wire [5:0] m_val = m_from_code(synth_control_reg[`CCS_SC_MCODE_HI:`CCS_SC_MCODE_LO]);
    // the reference is sampled as data on the system clock, so it must stay below half that rate
    wire ref_rise = REF_CLOCK_IN && !ref_d_reg;
    wire [1:0] active_src;
    wire switch_busy;
    wire core_halted;
    reg [1:0] want_src;

    // ----------------------------------------------------------------
    // apb slave: zero wait, registered read data latched in setup
    // ----------------------------------------------------------------
    assign PREADY = 1'b1;
    // unmapped places answer with an error in the access phase and read back as zero
    assign PSLVERR = PSEL && PENABLE && (sel_slot == 2'h0);

    // read data is captured in the setup cycle so it comes from a flip-flop
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (sel_slot)
                2'h1: PRDATA <= {16'h0000, synth_control_reg};
                2'h2: PRDATA <= {26'h0000000, core_halted, ref_present_reg, switch_busy, active_src, lock_reg};
                2'h3: PRDATA <= {30'h00000000, power_control_reg};
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // loop filter and spare bits are stored only; nothing in the model reads them
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            synth_control_reg <= `CCS_SC_RESET;
        end else if (synth_wr) begin
            synth_control_reg <= PWDATA[15:0];
        end
    end

    // a wake pin clears halt and wins over a write setting it in the same cycle
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            power_control_reg <= `CCS_PC_RESET;
        end else begin
            if (power_wr)
                power_control_reg <= PWDATA[1:0];
            if (EXT_WAKE0 || EXT_WAKE1)
                power_control_reg[`CCS_PC_HALT_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // reference edge watch and period measure
    // ----------------------------------------------------------------
    // a stalled reference saturates the counter and marks the reference absent
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ref_d_reg <= 1'b0;
            ref_period_cnt_reg <= 10'h000;
            ref_period_reg <= 10'h000;
            ref_present_reg <= 1'b0;
        end else begin
            ref_d_reg <= REF_CLOCK_IN;
            if (ref_rise) begin
                ref_period_reg <= ref_period_cnt_reg + 10'h001;
                ref_period_cnt_reg <= 10'h000;
                ref_present_reg <= (ref_period_cnt_reg != 10'h000);
            end else if (ref_period_cnt_reg == REF_TIMEOUT[9:0]) begin
                ref_present_reg <= 1'b0;
            end else begin
                ref_period_cnt_reg <= ref_period_cnt_reg + 10'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // lock detection
    // ----------------------------------------------------------------
    // a control write restarts the search; it is allowed to beat a lock in the same cycle
    // power-down drops the flag too, so a restart never trusts a stale lock
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            lock_reg <= 1'b0;
            detect_on_reg <= 1'b1;
            lock_cnt_reg <= 5'h00;
        end else if (synth_wr) begin
            lock_reg <= 1'b0;
            detect_on_reg <= 1'b1;
            lock_cnt_reg <= 5'h00;
        end else if (!synth_power) begin
            lock_reg <= 1'b0;
            detect_on_reg <= 1'b1;
            lock_cnt_reg <= 5'h00;
        end else if (detect_on_reg && ref_present_reg && ref_rise) begin
            if (lock_cnt_reg == LOCK_REF_EDGES[4:0] - 5'h01) begin
                lock_reg <= 1'b1;
                detect_on_reg <= 1'b0;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // synthesizer model
    // ----------------------------------------------------------------
    // oscillator ticks at ref*M/N: add M per cycle, wrap at N*ref period;
    // each tick toggles the level, so the level runs at half the oscillator rate
    // limitation: at most one tick per system cycle, so ref*M/N must stay below the system clock
    wire [14:0] wrap_at = {1'b0, n_val} * {4'h0, ref_period_reg};
    wire [14:0] acc_sum = vco_acc_reg + {9'h000, m_val};

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            vco_acc_reg <= 15'h0000;
            synth_lvl_reg <= 1'b0;
        end else if (!synth_power || !ref_present_reg) begin
            vco_acc_reg <= 15'h0000;
            synth_lvl_reg <= 1'b0;
        end else if (acc_sum >= wrap_at) begin
            vco_acc_reg <= acc_sum - wrap_at;
            synth_lvl_reg <= !synth_lvl_reg;
        end else begin
            vco_acc_reg <= acc_sum;
        end
    end

    // ----------------------------------------------------------------
    // ring oscillator model
    // ----------------------------------------------------------------
    // powered only while requested or still in use, so the switch can drain onto it
    assign RING_OSC_POWER_ON = ring_sel || (active_src == `CCS_SRC_RING);

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ring_cnt_reg <= 8'h00;
            ring_lvl_reg <= 1'b0;
        end else if (!RING_OSC_POWER_ON) begin
            ring_cnt_reg <= 8'h00;
            ring_lvl_reg <= 1'b0;
        end else if (ring_cnt_reg == RING_HALF[7:0] - 8'h01) begin
            ring_cnt_reg <= 8'h00;
            ring_lvl_reg <= !ring_lvl_reg;
        end else begin
            ring_cnt_reg <= ring_cnt_reg + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // source request with power-control priority
    // ----------------------------------------------------------------
    // ring select wins, then the synthesizer select, else the reference copy
    always @* begin
        if (ring_sel)
            want_src = `CCS_SRC_RING;
        else if (synth_sel)
            want_src = `CCS_SRC_SYNTH;
        else
            want_src = `CCS_SRC_REF;
    end

    // ----------------------------------------------------------------
    // glitch-free switch and outputs
    // ----------------------------------------------------------------
    ccs_glitch_switch u_switch (
        .clk(MCLK),
        .rst(RST),
        .src_lvl({ring_lvl_reg, synth_lvl_reg, REF_CLOCK_IN}),
        .sel(want_src),
        .halt(halt_req),
        .clk_out(CORE_CLOCK_OUT),
        .active(active_src),
        .busy(switch_busy),
        .halted(core_halted)
    );

    // power bit and settled flag go straight to pins so the board sees what firmware sees
    assign SYNTH_POWER_ON = synth_power;
    assign LOOP_SETTLED = lock_reg;

endmodule
`default_nettype wire

// >>> rtl/ccs_map.vh
// register offsets, field positions, reset values and timing constants of the clock source select
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CCS_OFS_SYNTH_CONTROL 8'h00
`define CCS_OFS_STATUS 8'h04
`define CCS_OFS_POWER_CONTROL 8'h08

// ----------------------------------------------------------------
// synth_control fields
// ----------------------------------------------------------------
`define CCS_SC_POWER_BIT 15
`define CCS_SC_SELECT_BIT 14
`define CCS_SC_LF_HI 11
`define CCS_SC_LF_LO 8
`define CCS_SC_NCODE_HI 7
`define CCS_SC_NCODE_LO 5
`define CCS_SC_MCODE_HI 4
`define CCS_SC_MCODE_LO 0
`define CCS_SC_RESET 16'h0000
`define CCS_NCODE_ONE 3'h7

// ----------------------------------------------------------------
// power_control fields
// ----------------------------------------------------------------
`define CCS_PC_RING_BIT 0
`define CCS_PC_HALT_BIT 1
`define CCS_PC_RESET 2'h0

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define CCS_ST_LOCK_BIT 0
`define CCS_ST_SRC_HI 2
`define CCS_ST_SRC_LO 1
`define CCS_ST_BUSY_BIT 3
`define CCS_ST_REF_BIT 4
`define CCS_ST_HALTED_BIT 5

// ----------------------------------------------------------------
// clock source codes
// ----------------------------------------------------------------
`define CCS_SRC_REF 2'h0
`define CCS_SRC_SYNTH 2'h1
`define CCS_SRC_RING 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCS_CLK_PERIOD_NS 10
`define CCS_LOCK_REF_EDGES 16
`define CCS_REF_TIMEOUT_CYCLES 1023
`define CCS_RING_HALF_CYCLES 8

`endif

// >>> rtl/ccs_glitch_switch.v
// glitch-free synchronous switch between clock source levels, with synchronous halt gate
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"

module ccs_glitch_switch (
    // clock and reset
    input wire clk,
    input wire rst,
    // source levels, indexed by source code
    input wire [2:0] src_lvl,
    input wire [1:0] sel,
    input wire halt,
    // gated clock and state
    output reg clk_out,
    output reg [1:0] active,
    output wire busy,
    output wire halted
);

    // ----------------------------------------------------------------
    // switch state machine
    // ----------------------------------------------------------------
    localparam ST_RUN = 1'b0;
    localparam ST_SWAP = 1'b1;

    reg state_reg;

    assign busy = (state_reg == ST_SWAP) && !halt;
    assign halted = (state_reg == ST_SWAP) && halt;

    // the old source is left only in its low phase and the new one joined only in its low
    // phase, so no short pulse can reach the core; the core clock is held low meanwhile
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RUN;
            clk_out <= 1'b0;
            active <= `CCS_SRC_REF;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if ((sel != active || halt) && !src_lvl[active]) begin
                        clk_out <= 1'b0;
                        state_reg <= ST_SWAP;
                    end else begin
                        clk_out <= src_lvl[active];
                    end
                end
                ST_SWAP: begin
                    clk_out <= 1'b0;
                    // halt holds the gate shut whatever the source
                    if (!halt && !src_lvl[sel]) begin
                        active <= sel;
                        state_reg <= ST_RUN;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                    clk_out <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> verification/ccs_clock_source_props.sv
// port-level assertion checker for the clock source select
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"
module ccs_clock_source_props (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    // clocks and state
    input wire logic REF_CLOCK_IN,
    input wire logic CORE_CLOCK_OUT,
    input wire logic SYNTH_POWER_ON,
    input wire logic LOOP_SETTLED
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    logic acc;
    logic wr_ctl;
    logic [1:0] age_reg;
    logic wrote_reg;
    assign acc = PSEL && PENABLE;
    assign wr_ctl = acc && PWRITE && (PADDR == `CCS_OFS_SYNTH_CONTROL);
    // age keeps the copy check clear of the reset edge; any write may move the source
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            age_reg <= 2'h0;
            wrote_reg <= 1'b0;
        end else begin
            age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
            wrote_reg <= wrote_reg | (acc & PWRITE);
        end
    end
    a_err_unmapped: assert property (acc |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08}))
        else $error("error response does not match address map");
    a_power_follows_write: assert property (wr_ctl |=> SYNTH_POWER_ON == $past(PWDATA[15]))
        else $error("synth power does not follow control write");
    a_lock_clear_write: assert property (wr_ctl |=> !LOOP_SETTLED)
        else $error("settled flag survived a control write");
    a_lock_off_unpowered: assert property (!SYNTH_POWER_ON [*2] |-> !LOOP_SETTLED)
        else $error("settled flag set while synth powered down");
    a_lock_needs_power: assert property ($rose(LOOP_SETTLED) |-> SYNTH_POWER_ON)
        else $error("settled flag rose without synth power");
    a_settled_holds: assert property (LOOP_SETTLED && !wr_ctl |=> LOOP_SETTLED)
        else $error("settled flag dropped without a control write");
    a_prdata_stands: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
        else $error("read data changed outside a read setup");
    a_core_ref_copy: assert property (age_reg == 2'h3 && !wrote_reg |-> CORE_CLOCK_OUT == $past(REF_CLOCK_IN))
        else $error("core clock is not a copy of the reference");
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking testbench for the clock source select
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic MCLK, RST, PSEL, PENABLE, PWRITE, REF_CLOCK_IN, EXT_WAKE0, EXT_WAKE1, ref_on, err;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [15:0] rnd, v;
    logic [1:0] ref_cnt;
    wire PREADY, PSLVERR, CORE_CLOCK_OUT, SYNTH_POWER_ON, RING_OSC_POWER_ON, LOOP_SETTLED;
    int n_mismatch, tests_run, i, w, ones, rises;

    always #5 MCLK = ~MCLK;

    // short lock and timeout counts keep the run brief
    ccs_clock_source #(.LOCK_REF_EDGES(4), .REF_TIMEOUT(63), .RING_HALF(8)) ccs_clock_source_i (
        .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .REF_CLOCK_IN(REF_CLOCK_IN), .CORE_CLOCK_OUT(CORE_CLOCK_OUT), .EXT_WAKE0(EXT_WAKE0),
        .EXT_WAKE1(EXT_WAKE1), .SYNTH_POWER_ON(SYNTH_POWER_ON), .RING_OSC_POWER_ON(RING_OSC_POWER_ON),
        .LOOP_SETTLED(LOOP_SETTLED));

    // reference of eight system cycles; kept slower than half the system clock
    always @(posedge MCLK) begin
        if (RST) begin
            ref_cnt <= 2'h0;
            REF_CLOCK_IN <= 1'b0;
        end else begin
            ref_cnt <= ref_cnt + 2'h1;
            if (ref_on && ref_cnt == 2'h3) REF_CLOCK_IN <= ~REF_CLOCK_IN;
        end
    end

    function automatic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // control word from power, select, filter, M and N
    function automatic [15:0] ctl_word(input p, input s, input [3:0] lf, input [4:0] m, input [3:0] n);
        ctl_word = {p, s, 2'b00, lf, (n == 4'h1) ? 3'h7 : 3'(n - 4'h2), 5'(m - 5'h2)};
    endfunction

    task complete_run;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // one apb transfer; result lands in rd and err
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge MCLK);
            if (PREADY === 1'b1) break;
        end
        if (k == 50) begin
            n_mismatch++;
            complete_run;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // poll status until the masked bits match, bounded
    task wait_st(input [31:0] mask, input [31:0] val);
        int k;
        for (k = 0; k < 500; k++) begin
            apb(1'b0, 8'h04, 32'h0);
            if ((rd & mask) === val) break;
        end
        chk(k < 500, 1);
        if (k == 500) complete_run;
    endtask

    // count high samples and rising edges of the core clock, sampled mid-cycle where it is settled
    task watch_core(input int cycles);
        logic prev;
        ones = 0;
        rises = 0;
        @(negedge MCLK);
        prev = CORE_CLOCK_OUT;
        repeat (cycles) begin
            @(negedge MCLK);
            ones += (CORE_CLOCK_OUT !== 1'b0);
            rises += (CORE_CLOCK_OUT === 1'b1 && prev === 1'b0);
            prev = CORE_CLOCK_OUT;
        end
        @(posedge MCLK);
    endtask

    initial begin
        MCLK = 0; RST = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0;
        EXT_WAKE0 = 0; EXT_WAKE1 = 0; ref_on = 1;
        n_mismatch = 0; tests_run = 0; rnd = 16'h0025;
        repeat (3) @(posedge MCLK);
        RST <= 1'b0;
        // reset state
        apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0); chk(rd & 32'h2f, 32'h0);
        // unmapped place refused, status write ignored quietly
        apb(1'b1, 8'h0c, 32'hffff_ffff); chk(err, 1);
        apb(1'b0, 8'h0c, 32'h0); chk(rd, 32'h0);
        apb(1'b1, 8'h04, 32'hffff); chk(err, 0);
        // divider settings with synth off, extreme M and N first
        for (i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            v = ctl_word(1'b0, 1'b0, rnd[11:8], (i == 0) ? 5'd2 : (i == 1) ? 5'd20 : 5'd2 + 5'(rnd[4:0] % 19),
                (i == 0) ? 4'd1 : (i == 1) ? 4'd8 : 4'd1 + 4'(rnd[7:5]));
            apb(1'b1, 8'h00, {lfsr(rnd), v});
            apb(1'b0, 8'h00, 32'h0); chk(rd, {16'h0, v});
        end
        // power up with M=4 and N=1, so the oscillator runs at four times the reference
        apb(1'b1, 8'h00, {16'h0, ctl_word(1'b1, 1'b0, 4'h9, 5'd4, 4'd1)});
        wait_st(32'h1, 32'h1);
        chk(rd[4], 1);
        apb(1'b1, 8'h00, {16'h0, ctl_word(1'b1, 1'b1, 4'h9, 5'd4, 4'd1)});
        wait_st(32'h6, 32'h2);
        // core at half the oscillator: one rise per 2*N*8/M system cycles, high half the time
        watch_core(64);
        chk(rises, 64 * 4 / (2 * 1 * 8));
        chk(ones, 32);
        apb(1'b1, 8'h00, {16'h0, ctl_word(1'b1, 1'b0, 4'h9, 5'd4, 4'd1)});
        wait_st(32'h6, 32'h0);
        // ring oscillator override
        apb(1'b1, 8'h08, 32'h1);
        wait_st(32'h6, 32'h4);
        chk(RING_OSC_POWER_ON, 1);
        apb(1'b1, 8'h08, 32'h0);
        wait_st(32'h6, 32'h0);
        @(posedge MCLK);
        chk(RING_OSC_POWER_ON, 0);
        // halt, released by each wake pin in turn
        for (w = 0; w < 2; w++) begin
            apb(1'b1, 8'h08, 32'h2);
            wait_st(32'h20, 32'h20);
            watch_core(20);
            chk(ones, 0);
            EXT_WAKE0 <= (w == 0);
            EXT_WAKE1 <= (w == 1);
            @(posedge MCLK);
            EXT_WAKE0 <= 1'b0;
            EXT_WAKE1 <= 1'b0;
            apb(1'b0, 8'h08, 32'h0); chk(rd, 32'h0);
            wait_st(32'h20, 32'h0);
        end
        // power down before the reference stops; with no reference the synth must not settle
        apb(1'b1, 8'h00, {16'h0, ctl_word(1'b0, 1'b0, 4'h9, 5'd4, 4'd1)});
        ref_on <= 1'b0;
        apb(1'b1, 8'h00, {16'h0, ctl_word(1'b1, 1'b0, 4'h9, 5'd4, 4'd1)});
        repeat (200) @(posedge MCLK);
        chk(LOOP_SETTLED, 0);
        apb(1'b0, 8'h04, 32'h0); chk(rd[4], 0);
        // second reset in mid-run
        RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        RST <= 1'b0;
        ref_on <= 1'b1;
        apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0);
        chk(SYNTH_POWER_ON, 0);
        complete_run;
    end
endmodule

bind ccs_clock_source ccs_clock_source_props ccs_clock_source_props_i (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .REF_CLOCK_IN(REF_CLOCK_IN),
    .CORE_CLOCK_OUT(CORE_CLOCK_OUT), .SYNTH_POWER_ON(SYNTH_POWER_ON), .LOOP_SETTLED(LOOP_SETTLED));
`default_nettype wire
